// ==== rtl/pls_pkg.sv ====
// Purpose: Shared constants for the synthesizer digital core and its serial host
// Assumes: One 20 MHz clock on both ends
// Notes:   Field positions follow the 24-bit word layout
//
// Overview of operation
// - Feedback ratio equals P times B plus A
// - Prescaler selectable 8/9, 16/17 or 32/33
// - Host flags ratio below P squared minus P but still sends it
// - B counter 13 bits, A counter 5 bits
// - Reference divider 14 bits, ratio 1 to 16383
// - Two bits select anti-backlash pulse width
// - Three bits select muxed test output source
// - Precision 0: lock after three good cycles
// - Precision 1: lock after five good cycles
// - Lock drops on error above 25 ns
// - Shift 24 bits on serial clock rise, MSB first
// - Load strobe rise copies word to selected latch
// - Selector: control, reference, A/B, test latch
// - Host never addresses the test latch
// - Band select at power-up and A/B write
// - Band select five cycles, tuning held meanwhile
// - Host order: reference, control, then A/B
// - Band clock divides reference output by 1,2,4,8
// - Two-bit core current and output level fields
// - Mute-until-locked holds output stage off
// - Bit 22 of A/B latch selects half rate
package pls_pkg;
	localparam int WORD_W = 24;

	// ----------------------------------------------------------------
	// Latch selector
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_CTRL = 2'h0;
	localparam logic [1:0] SEL_REF  = 2'h1;
	localparam logic [1:0] SEL_AB   = 2'h2;
	localparam logic [1:0] SEL_TEST = 2'h3;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PRE_LSB     = 22;
	localparam int OLEV_LSB    = 12;
	localparam int MUTE_BIT    = 11;
	localparam int OSEL_LSB    = 5;
	localparam int CRST_BIT    = 4;
	localparam int CORE_LSB    = 2;
	localparam int HALF_BIT    = 22;
	localparam int B_LSB       = 8;
	localparam int B_W         = 13;
	localparam int A_LSB       = 2;
	localparam int A_W         = 5;
	localparam int BSC_LSB     = 20;
	localparam int PREC_BIT    = 18;
	localparam int ABP_LSB     = 16;
	localparam int R_LSB       = 2;
	localparam int R_W         = 14;

	// ----------------------------------------------------------------
	// Timing and counts
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int LOCK_SET_NS   = 15;
	localparam int UNLOCK_NS     = 25;
	localparam int LOCK_CNT_LO   = 3;
	localparam int LOCK_CNT_HI   = 5;
	localparam int BAND_STEPS    = 5;
	localparam int BAND_SAR_STEPS = 3;
	localparam logic [2:0] BAND_INIT = 3'h4;

	// ----------------------------------------------------------------
	// Output multiplexer codes
	// ----------------------------------------------------------------
	localparam logic [2:0] MUX_LOW   = 3'h0;
	localparam logic [2:0] MUX_DLOCK = 3'h1;
	localparam logic [2:0] MUX_NDIV  = 3'h2;
	localparam logic [2:0] MUX_HIGH  = 3'h3;
	localparam logic [2:0] MUX_RDIV  = 3'h4;
	localparam logic [2:0] MUX_ALOCK = 3'h5;

	// ----------------------------------------------------------------
	// Host register map
	// ----------------------------------------------------------------
	localparam logic [7:0] HREG_WORD   = 8'h00;
	localparam logic [7:0] HREG_CMD    = 8'h04;
	localparam logic [7:0] HREG_STATUS = 8'h08;
	localparam int ST_BUSY  = 0;
	localparam int ST_TEST  = 1;
	localparam int ST_ORDER = 2;
	localparam int ST_RATIO = 3;

	typedef enum logic [2:0] {
		H_IDLE   = 3'b001,
		H_SHIFT  = 3'b010,
		H_STROBE = 3'b100
	} pls_hstate_t;

	typedef enum logic [1:0] {
		B_IDLE = 2'b01,
		B_RUN  = 2'b10
	} pls_bstate_t;

	// Prescaler modulus P from the two-bit select
	function automatic logic [5:0] pre_mod(input logic [1:0] sel);
		unique case (sel)
			2'h0:    pre_mod = 6'h08;
			2'h1:    pre_mod = 6'h10;
			default: pre_mod = 6'h20;
		endcase
	endfunction
endpackage

// ==== rtl/pls_if.sv ====
`timescale 1ns/1ps
// Purpose: Three-wire serial link between host and synthesizer core
// Assumes: Host drives all three wires
// Notes:   No clocking block
interface pls_if;
	logic sclk;
	logic sdata;
	logic load_strobe;

	modport host (output sclk, output sdata, output load_strobe);
	modport dev  (input sclk, input sdata, input load_strobe);
endinterface

// ==== rtl/pls_device.sv ====
`timescale 1ns/1ps
// Purpose: Digital core of an integer-N synthesizer
// Assumes: Serial, reference and VCO inputs are asynchronous pins, the prescaler is inside
// Notes:   Phase error is measured in whole clock cycles
module pls_device #(
	parameter int ERR_W = 8
) (
	input  wire logic       I_CLK,
	input  wire logic       I_RST,
	pls_if.dev              PINS,
	input  wire logic       I_REFERENCE_INPUT,
	input  wire logic       I_VCO_IN,
	output logic            O_LOCK,
	output logic            O_MUXED_TEST_OUTPUT,
	output logic            O_VCO_TUNING_INPUT_HOLD,
	output logic [2:0]      O_BAND,
	output logic [1:0]      O_CORE_CURRENT,
	output logic [1:0]      O_OUT_LEVEL,
	output logic [1:0]      O_BACKLASH_WIDTH,
	output logic            O_RF_ON,
	output logic            O_HALF_RATE_OUTPUT
);
	import pls_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0]        sclk_sy, le_sy, ref_sy, vco_sy;
	logic [1:0]        sdat_sy;
	logic              sclk_rise, le_rise, ref_rise, vco_rise;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			sclk_sy <= '0;
			le_sy   <= '0;
			ref_sy  <= '0;
			vco_sy  <= '0;
			sdat_sy <= '0;
		end else begin
			sclk_sy <= {sclk_sy[1:0], PINS.sclk};
			le_sy   <= {le_sy[1:0], PINS.load_strobe};
			ref_sy  <= {ref_sy[1:0], I_REFERENCE_INPUT};
			vco_sy  <= {vco_sy[1:0], I_VCO_IN};
			sdat_sy <= {sdat_sy[0], PINS.sdata};
		end
	end

	assign sclk_rise = sclk_sy[1] & ~sclk_sy[2];
	assign le_rise   = le_sy[1] & ~le_sy[2];
	assign ref_rise  = ref_sy[1] & ~ref_sy[2];
	assign vco_rise  = vco_sy[1] & ~vco_sy[2];

	// ----------------------------------------------------------------
	// Shift register and latches
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] shift_reg, ctrl_reg, ref_reg, ab_reg, test_reg;
	logic              ab_load_reg;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			shift_reg <= '0;
		end else if (sclk_rise) begin
			shift_reg <= {shift_reg[WORD_W-2:0], sdat_sy[1]};
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ctrl_reg    <= '0;
			ref_reg     <= '0;
			ab_reg      <= '0;
			test_reg    <= '0;
			ab_load_reg <= 1'b0;
		end else begin
			ab_load_reg <= 1'b0;
			if (le_rise) begin
				unique case (shift_reg[1:0])
					SEL_CTRL: ctrl_reg <= shift_reg;
					SEL_REF:  ref_reg  <= shift_reg;
					SEL_AB: begin
						ab_reg      <= shift_reg;
						ab_load_reg <= 1'b1;
					end
					SEL_TEST: test_reg <= shift_reg;
				endcase
			end
		end
	end

	logic [B_W-1:0]  b_val;
	logic [A_W-1:0]  a_val;
	logic [R_W-1:0]  r_val;
	logic [5:0]      p_val;
	logic            cnt_hold;

	assign b_val    = ab_reg[B_LSB +: B_W];
	assign a_val    = ab_reg[A_LSB +: A_W];
	assign r_val    = ref_reg[R_LSB +: R_W];
	assign p_val    = pre_mod(ctrl_reg[PRE_LSB +: 2]);
	assign cnt_hold = ctrl_reg[CRST_BIT];

	// ----------------------------------------------------------------
	// Prescaler and A/B counters
	// ----------------------------------------------------------------
	logic [5:0]      pre_cnt;
	logic            pre_out;
	logic [B_W-1:0]  b_left;
	logic [A_W-1:0]  a_left;
	logic            n_pulse;
	logic [5:0]      cur_mod;

	assign cur_mod = (a_left != '0) ? p_val + 6'h01 : p_val;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			pre_cnt <= '0;
			pre_out <= 1'b0;
		end else if (cnt_hold) begin
			pre_cnt <= '0;
			pre_out <= 1'b0;
		end else begin
			pre_out <= 1'b0;
			if (vco_rise) begin
				if (pre_cnt >= cur_mod - 6'h01) begin
					pre_cnt <= '0;
					pre_out <= 1'b1;
				end else begin
					pre_cnt <= pre_cnt + 6'h01;
				end
			end
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			b_left  <= '0;
			a_left  <= '0;
			n_pulse <= 1'b0;
		end else if (cnt_hold) begin
			b_left  <= b_val;
			a_left  <= a_val;
			n_pulse <= 1'b0;
		end else begin
			n_pulse <= 1'b0;
			if (pre_out) begin
				if (b_left <= B_W'(1)) begin
					b_left  <= b_val;
					a_left  <= a_val;
					n_pulse <= 1'b1;
				end else begin
					b_left <= b_left - B_W'(1);
					if (a_left != '0) begin
						a_left <= a_left - A_W'(1);
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Reference divider
	// ----------------------------------------------------------------
	logic [R_W-1:0]  r_cnt;
	logic            r_pulse;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			r_cnt   <= '0;
			r_pulse <= 1'b0;
		end else if (cnt_hold) begin
			r_cnt   <= '0;
			r_pulse <= 1'b0;
		end else begin
			r_pulse <= 1'b0;
			if (ref_rise) begin
				if (r_cnt + R_W'(1) >= r_val) begin
					r_cnt   <= '0;
					r_pulse <= 1'b1;
				end else begin
					r_cnt <= r_cnt + R_W'(1);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Phase error measurement
	// ----------------------------------------------------------------
	logic             ref_wait, n_wait, pd_done;
	logic [ERR_W-1:0] err_cnt, pd_err;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ref_wait <= 1'b0;
			n_wait   <= 1'b0;
			err_cnt  <= '0;
			pd_err   <= '0;
			pd_done  <= 1'b0;
		end else begin
			pd_done <= 1'b0;
			if (err_cnt != '1) begin
				err_cnt <= err_cnt + ERR_W'(1);
			end
			if (r_pulse && n_pulse) begin
				pd_err   <= '0;
				pd_done  <= 1'b1;
				ref_wait <= 1'b0;
				n_wait   <= 1'b0;
			end else if ((r_pulse && n_wait) || (n_pulse && ref_wait)) begin
				pd_err   <= err_cnt;
				pd_done  <= 1'b1;
				ref_wait <= 1'b0;
				n_wait   <= 1'b0;
			end else if (r_pulse || n_pulse) begin
				ref_wait <= r_pulse;
				n_wait   <= n_pulse;
				err_cnt  <= ERR_W'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// Digital lock detector
	// ----------------------------------------------------------------
	logic        lock_reg;
	logic [2:0]  good_cnt, good_need;
	logic        pd_good, pd_bad;

	assign pd_good   = (32'(pd_err) * CLK_PERIOD_NS) < LOCK_SET_NS;
	assign pd_bad    = (32'(pd_err) * CLK_PERIOD_NS) > UNLOCK_NS;
	assign good_need = ref_reg[PREC_BIT] ? 3'(LOCK_CNT_HI) : 3'(LOCK_CNT_LO);

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			lock_reg <= 1'b0;
			good_cnt <= '0;
		end else if (pd_done) begin
			if (pd_bad) begin
				lock_reg <= 1'b0;
			end
			if (!pd_good) begin
				good_cnt <= '0;
			end else if (good_cnt + 3'h1 >= good_need) begin
				good_cnt <= good_need;
				lock_reg <= 1'b1;
			end else begin
				good_cnt <= good_cnt + 3'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Band select
	// ----------------------------------------------------------------
	pls_bstate_t     bs_state;
	logic [2:0]      bs_div, bs_step, band_reg, bs_bit;
	logic            bs_tick, bs_run_reg;
	logic signed [7:0] bal;

	assign bs_tick = r_pulse && (bs_div == 3'((1 << ref_reg[BSC_LSB +: 2]) - 1));
	assign bs_bit  = 3'(BAND_INIT >> bs_step);

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			bs_div <= '0;
		end else if (bs_tick) begin
			bs_div <= '0;
		end else if (r_pulse) begin
			bs_div <= bs_div + 3'h1;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			bal <= '0;
		end else if (bs_tick) begin
			bal <= '0;
		end else if (n_pulse != r_pulse) begin
			bal <= n_pulse ? bal + 8'sh01 : bal - 8'sh01;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			bs_state   <= B_RUN;
			bs_step    <= '0;
			band_reg   <= BAND_INIT;
			bs_run_reg <= 1'b1;
		end else begin
			unique case (bs_state)
				B_IDLE: begin
					if (ab_load_reg) begin
						bs_state   <= B_RUN;
						bs_step    <= '0;
						band_reg   <= BAND_INIT;
						bs_run_reg <= 1'b1;
					end
				end
				B_RUN: begin
					if (ab_load_reg) begin
						bs_step  <= '0;
						band_reg <= BAND_INIT;
					end else if (bs_tick) begin
						if (bs_step < 3'(BAND_SAR_STEPS)) begin
							band_reg <= (bal > 8'sh00) ? ((band_reg & ~bs_bit) | (bs_bit >> 1))
							                           : (band_reg | (bs_bit >> 1));
						end
						if (bs_step == 3'(BAND_STEPS - 1)) begin
							bs_state   <= B_IDLE;
							bs_run_reg <= 1'b0;
						end else begin
							bs_step <= bs_step + 3'h1;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic n_tog, r_tog, mux_reg, rf_reg;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			n_tog <= 1'b0;
			r_tog <= 1'b0;
		end else begin
			n_tog <= n_tog ^ n_pulse;
			r_tog <= r_tog ^ r_pulse;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			mux_reg <= 1'b0;
		end else begin
			unique case (ctrl_reg[OSEL_LSB +: 3])
				MUX_DLOCK: mux_reg <= lock_reg;
				MUX_NDIV:  mux_reg <= n_tog;
				MUX_HIGH:  mux_reg <= 1'b1;
				MUX_RDIV:  mux_reg <= r_tog;
				MUX_ALOCK: mux_reg <= ~(ref_wait | n_wait);
				default:   mux_reg <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			rf_reg <= 1'b0;
		end else begin
			rf_reg <= ~ctrl_reg[MUTE_BIT] | lock_reg;
		end
	end

	assign O_LOCK                  = lock_reg;
	assign O_MUXED_TEST_OUTPUT     = mux_reg;
	assign O_VCO_TUNING_INPUT_HOLD = bs_run_reg;
	assign O_BAND                  = band_reg;
	assign O_CORE_CURRENT          = ctrl_reg[CORE_LSB +: 2];
	assign O_OUT_LEVEL             = ctrl_reg[OLEV_LSB +: 2];
	assign O_BACKLASH_WIDTH        = ref_reg[ABP_LSB +: 2];
	assign O_RF_ON                 = rf_reg;
	assign O_HALF_RATE_OUTPUT      = ab_reg[HALF_BIT];
endmodule // pls_device

// ==== rtl/pls_host.sv ====
`timescale 1ns/1ps
// Purpose: APB-controlled serial host for the synthesizer core
// Assumes: APB3 master on the same clock
// Notes:   Refused words are never shifted out
module pls_host #(
	parameter int SCLK_HALF = 2
) (
	input  wire logic       I_CLK,
	input  wire logic       I_RST,
	input  wire logic       I_PSEL,
	input  wire logic       I_PENABLE,
	input  wire logic       I_PWRITE,
	input  wire logic [7:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic [31:0]     O_PRDATA,
	output logic            O_PREADY,
	output logic            O_PSLVERR,
	pls_if.host             PINS
);
	import pls_pkg::*;

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	pls_hstate_t       st;
	logic [WORD_W-1:0] word_reg, shift_reg, last_ctrl_reg;
	logic [3:0]        sts_val;
	logic [3:1]        flag_reg;
	logic [31:0]       prdata_reg;
	logic              pready_reg, pslverr_reg, setup, wr_acc, go;
	logic              r_seen, c_seen, refuse_test, refuse_order, ratio_low;
	logic [1:0]        wsel;
	logic [19:0]       n_ratio, n_min;
	logic [5:0]        p_last;

	assign setup  = I_PSEL & ~I_PENABLE;
	assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE & pready_reg;
	assign go     = wr_acc && (I_PADDR == HREG_CMD) && I_PWDATA[0] && (st == H_IDLE);
	assign wsel   = word_reg[1:0];
	assign refuse_test  = go && (wsel == SEL_TEST);
	assign refuse_order = go && (((wsel == SEL_CTRL) && !r_seen) ||
	                             ((wsel == SEL_AB) && !c_seen));
	assign p_last  = pre_mod(last_ctrl_reg[PRE_LSB +: 2]);
	assign n_ratio = 20'(word_reg[B_LSB +: B_W]) * 20'(p_last) + 20'(word_reg[A_LSB +: A_W]);
	assign n_min   = 20'(p_last) * 20'(p_last) - 20'(p_last);
	assign ratio_low = go && (wsel == SEL_AB) && (n_ratio < n_min);

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= '0;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup && (I_PADDR != HREG_WORD) && (I_PADDR != HREG_CMD) &&
			               (I_PADDR != HREG_STATUS);
			if (setup && !I_PWRITE) begin
				unique case (I_PADDR)
					HREG_WORD:   prdata_reg <= 32'(word_reg);
					HREG_STATUS: prdata_reg <= 32'(sts_val);
					default:     prdata_reg <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			word_reg <= '0;
		end else if (wr_acc && (I_PADDR == HREG_WORD)) begin
			word_reg <= I_PWDATA[WORD_W-1:0];
		end
	end

	// Error flags: write one clears, a new event wins
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			flag_reg <= '0;
		end else begin
			if (wr_acc && (I_PADDR == HREG_STATUS)) begin
				flag_reg <= flag_reg & ~I_PWDATA[3:1];
			end
			if (refuse_test) begin
				flag_reg[ST_TEST] <= 1'b1;
			end
			if (refuse_order) begin
				flag_reg[ST_ORDER] <= 1'b1;
			end
			if (ratio_low) begin
				flag_reg[ST_RATIO] <= 1'b1;
			end
		end
	end

	assign sts_val = {flag_reg, st != H_IDLE};

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			r_seen        <= 1'b0;
			c_seen        <= 1'b0;
			last_ctrl_reg <= '0;
		end else if (go && !refuse_test && !refuse_order) begin
			if (wsel == SEL_REF) begin
				r_seen <= 1'b1;
			end
			if (wsel == SEL_CTRL) begin
				c_seen        <= 1'b1;
				last_ctrl_reg <= word_reg;
			end
		end
	end

	// ----------------------------------------------------------------
	// Serial engine
	// ----------------------------------------------------------------
	logic [7:0] tick_cnt;
	logic [4:0] bit_cnt;
	logic       sclk_reg, sdata_reg, le_reg;

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			st        <= H_IDLE;
			shift_reg <= '0;
			tick_cnt  <= '0;
			bit_cnt   <= '0;
			sclk_reg  <= 1'b0;
			sdata_reg <= 1'b0;
			le_reg    <= 1'b0;
		end else begin
			unique case (st)
				H_IDLE: begin
					if (go && !refuse_test && !refuse_order) begin
						st        <= H_SHIFT;
						shift_reg <= {word_reg[WORD_W-2:0], 1'b0};
						sdata_reg <= word_reg[WORD_W-1];
						tick_cnt  <= '0;
						bit_cnt   <= '0;
					end
				end
				H_SHIFT: begin
					tick_cnt <= tick_cnt + 8'h01;
					if (tick_cnt == 8'(SCLK_HALF - 1)) begin
						sclk_reg <= 1'b1;
					end else if (tick_cnt == 8'(2 * SCLK_HALF - 1)) begin
						sclk_reg <= 1'b0;
						tick_cnt <= '0;
						if (bit_cnt == 5'(WORD_W - 1)) begin
							st <= H_STROBE;
						end else begin
							bit_cnt   <= bit_cnt + 5'h01;
							sdata_reg <= shift_reg[WORD_W-1];
							shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
						end
					end
				end
				H_STROBE: begin
					tick_cnt <= tick_cnt + 8'h01;
					if (tick_cnt == 8'(SCLK_HALF - 1)) begin
						le_reg <= 1'b1;
					end else if (tick_cnt == 8'(3 * SCLK_HALF - 1)) begin
						le_reg <= 1'b0;
					end else if (tick_cnt == 8'(4 * SCLK_HALF - 1)) begin
						st <= H_IDLE;
					end
				end
			endcase
		end
	end

	assign PINS.sclk        = sclk_reg;
	assign PINS.sdata       = sdata_reg;
	assign PINS.load_strobe = le_reg;
	assign O_PRDATA         = prdata_reg;
	assign O_PREADY         = pready_reg;
	assign O_PSLVERR        = pslverr_reg;
endmodule // pls_host

// ==== bench/pls_properties.sv ====
// Purpose: Checks on the three serial wires
// Assumes: SCLK_HALF of 2
// Notes:   Instanced beside the link
`timescale 1ns/1ps
module pls_properties (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic load_strobe
);
	import pls_pkg::*;
	logic [23:0] sh_reg;
	logic [5:0]  n_reg;
	logic        sd_reg, ld_reg, rf_reg, ct_reg;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	// ----
	// Word capture
	// ----
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			sd_reg <= 1'h0;
			sh_reg <= '0;
			n_reg  <= '0;
		end else begin
			sd_reg <= sclk;
			if (sclk && !sd_reg) begin
				sh_reg <= {sh_reg[22:0], sdata};
				n_reg  <= n_reg + 6'h01;
			end else if (load_strobe) begin
				n_reg <= '0;
			end
		end
	end
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			ld_reg <= 1'h0;
			rf_reg <= 1'h0;
			ct_reg <= 1'h0;
		end else begin
			ld_reg <= load_strobe;
			if (load_strobe && !ld_reg) begin
				rf_reg <= rf_reg | (sh_reg[1:0] == SEL_REF);
				ct_reg <= ct_reg | (sh_reg[1:0] == SEL_CTRL);
			end
		end
	end
	data_hold_a: assert property (sclk |-> $stable(sdata))
		else $error("sdata moved");
	clk_high_a: assert property ($rose(sclk) |=> sclk ##1 !sclk)
		else $error("sclk high width");
	clk_low_a: assert property ($fell(sclk) |-> !sclk [*2])
		else $error("sclk low width");
	strobe_len_a: assert property ($rose(load_strobe) |-> load_strobe [*4] ##1 !load_strobe)
		else $error("strobe width");
	strobe_quiet_a: assert property (load_strobe |-> !sclk)
		else $error("sclk in strobe");
	bit_count_a: assert property ($rose(load_strobe) |-> n_reg == 6'h18)
		else $error("bit count");
	no_test_a: assert property ($rose(load_strobe) |-> sh_reg[1:0] != SEL_TEST)
		else $error("test latch sent");
	load_order_a: assert property ($rose(load_strobe) |->
		(sh_reg[1:0] != SEL_CTRL || rf_reg) && (sh_reg[1:0] != SEL_AB || ct_reg))
		else $error("load order");
endmodule // pls_properties

// ==== bench/pll_synth_digital_core_tb.sv ====
// Purpose: Bench for host and core over the link
// Assumes: SCLK_HALF 2, P 8, B 3, A 0, R 1
// Notes:   Lock found by slipping VCO edges
`timescale 1ns/1ps
module pll_synth_digital_core_tb;
	import pls_pkg::*;
	logic        I_CLK = 1'h0, I_RST = 1'h1, ps = 1'h0, pe = 1'h0, pw = 1'h0;
	logic        rin = 1'h0, vco = 1'h0, skip = 1'h0, se, rdy, er, lk, mx, hd, rf, hf;
	logic [7:0]  pa = 8'h00;
	logic [31:0] wd = '0, rd, prd, r, seed = 32'h0000_92fc;
	logic [2:0]  bd;
	logic [2:0]  codes [3] = '{MUX_LOW, MUX_HIGH, MUX_DLOCK};
	logic [1:0]  cc, ol, ab;
	logic [23:0] w;
	int          errors = 0, compares = 0, cyc = 0;
	pls_if pins();
	pls_host pls_host_i (.I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(ps), .I_PENABLE(pe),
		.I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(wd), .O_PRDATA(prd), .O_PREADY(rdy),
		.O_PSLVERR(er), .PINS(pins));
	pls_device pls_device_i (.I_CLK(I_CLK), .I_RST(I_RST), .PINS(pins),
		.I_REFERENCE_INPUT(rin), .I_VCO_IN(vco), .O_LOCK(lk), .O_MUXED_TEST_OUTPUT(mx),
		.O_VCO_TUNING_INPUT_HOLD(hd), .O_BAND(bd), .O_CORE_CURRENT(cc), .O_OUT_LEVEL(ol),
		.O_BACKLASH_WIDTH(ab), .O_RF_ON(rf), .O_HALF_RATE_OUTPUT(hf));
	pls_properties pls_properties_i (.I_CLK(I_CLK), .I_RST(I_RST), .sclk(pins.sclk),
		.sdata(pins.sdata), .load_strobe(pins.load_strobe));
	// ----
	// Clocks and helpers
	// ----
	initial forever #25 I_CLK = ~I_CLK;
	always @(posedge I_CLK) begin
		cyc <= cyc + 1;
		rin <= ((cyc + 1) % 48) < 24;
		vco <= !cyc[0] && !skip;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic low_ratio(int p, int b, int a);
		return p * b + a < p * p - p;
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, s, x);
		end
	endtask
	task automatic end_of_test();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge I_CLK);
		ps <= 1'h1;
		pw <= wr;
		pa <= a;
		wd <= d;
		@(posedge I_CLK);
		pe <= 1'h1;
		do begin
			@(posedge I_CLK);
			n++;
		end while (rdy !== 1'h1 && n < 20);
		rd = prd;
		se = er;
		ps <= 1'h0;
		pe <= 1'h0;
		if (rdy !== 1'h1) begin
			errors++;
			end_of_test();
		end
	endtask
	task automatic send(input logic [23:0] v);
		int n;
		n = 0;
		apb(1'h1, HREG_WORD, {8'h00, v});
		apb(1'h1, HREG_CMD, 32'h0000_0001);
		do begin
			apb(1'h0, HREG_STATUS, '0);
			n++;
		end while (rd[ST_BUSY] !== 1'h0 && n < 200);
		chk(rd[ST_BUSY], 1'h0);
		if (rd[ST_BUSY] !== 1'h0) end_of_test();
		repeat (8) @(posedge I_CLK);
	endtask
	task automatic flag(input int b, input logic x);
		apb(1'h0, HREG_STATUS, '0);
		chk(rd[b], x);
		apb(1'h1, HREG_STATUS, 32'h0000_0001 << b);
	endtask
	task automatic slip();
		@(posedge I_CLK);
		skip <= 1'h1;
		repeat (2) @(posedge I_CLK);
		skip <= 1'h0;
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		repeat (5) @(posedge I_CLK);
		chk(hd, 1'h1);
		chk(bd, BAND_INIT);
		I_RST <= 1'h0;
		apb(1'h0, 8'h10, '0);
		chk(se, 1'h1);
		chk(rd, '0);
		r = rnd();
		w = {1'h0, r[22], 1'h0, 13'h0003, 1'h0, 5'h00, SEL_AB};
		send(w);
		flag(ST_ORDER, 1'h1);
		send({r[23:2], SEL_TEST});
		flag(ST_TEST, 1'h1);
		send({6'h00, r[1:0], 14'h0001, SEL_REF});
		chk(ab, r[1:0]);
		foreach (codes[i]) begin
			r = rnd();
			send({10'h000, r[3:2], 1'h1, 3'h0, codes[i], 1'h0, r[1:0], SEL_CTRL});
			chk(cc, r[1:0]);
			chk(ol, r[3:2]);
			if (i < 2) chk(mx, codes[i] == MUX_HIGH);
		end
		send(w);
		chk(hf, w[HALF_BIT]);
		chk(hd, 1'h1);
		flag(ST_RATIO, low_ratio(8, 3, 0));
		for (int k = 0; k < 30 && lk !== 1'h1; k++) begin
			slip();
			repeat (240) @(posedge I_CLK);
		end
		chk(lk, 1'h1);
		chk(hd, 1'h0);
		chk(mx, 1'h1);
		chk(rf, 1'h1);
		slip();
		repeat (100) @(posedge I_CLK);
		chk(lk, 1'h0);
		chk(rf, 1'h0);
		send({5'h00, 1'h1, 2'h0, 14'h0001, SEL_REF});
		chk(ab, 2'h0);
		repeat (23) begin
			slip();
			@(posedge I_CLK);
		end
		repeat (170) @(posedge I_CLK);
		chk(lk, 1'h0);
		repeat (90) @(posedge I_CLK);
		chk(lk, 1'h1);
		end_of_test();
	end
endmodule // pll_synth_digital_core_tb
